/* File: common/cie_pkg.sv */
// Purpose: shared constants for the interrupt entry sequencer
// Assumes: 8-bit core bus, 16-bit addresses, stack grows downward
// Notes: stacking order is low byte of return address first
package cie_pkg;
    localparam int CIE_NUM_SRC = 8;
    localparam int CIE_ADDR_W = 16;
    localparam logic [15:0] CIE_VEC_TOP = 16'hFFFE;
    localparam logic [15:0] CIE_SP_RESET = 16'h00FF;
    localparam logic [7:0] CIE_CCR_RESET = 8'h68;
    localparam int CIE_CCR_IBIT = 3;
    localparam int CIE_QUEUE_BYTES = 3;
    localparam int CIE_STACK_BYTES = 5;
    typedef enum logic [1:0] {
        CIE_OP_NONE,
        CIE_OP_SWI,
        CIE_OP_RTI,
        CIE_OP_CLI
    } cie_op_e;
endpackage

/* File: hdl/cie_stack_mem.sv */
// Purpose: small byte memory holding stacked registers
// Assumes: one write or one read per cycle
// Notes: read data is registered, one cycle latency
`timescale 1ns/1ps
module cie_stack_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];
    logic [7:0] next_rdata;

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("depth too large for address width");
        end
    end

    always_comb begin
        next_rdata = mem[addr_i];
    end

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= next_rdata;
    end
endmodule

/* File: hdl/cie_entry.sv */
// Purpose: interrupt acceptance and entry sequencing for the core
// Assumes: event inputs come from pins, so they are synchronised
// Notes: core signals instruction end; entry is identical to a trap
//
// How it works
// - enabled source event sets read-only status flag
// - respond only when enabled and mask clear
// - reset sets the global mask bit
// - finish current instruction before entry begins
// - hardware entry reuses the trap sequence
// - stack, mask, fetch vector, fill queue
// - return restores mask from stacked flags
// - debug module can raise a trap
`timescale 1ns/1ps
module cie_entry
    import cie_pkg::*;
#(
    parameter int NUM_SRC = cie_pkg::CIE_NUM_SRC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [NUM_SRC-1:0] event_i,
    input wire logic [NUM_SRC-1:0] local_en_i,
    input wire logic [NUM_SRC-1:0] flag_clr_i,
    input wire logic insn_done_i,
    input wire cie_pkg::cie_op_e op_i,
    input wire logic dbg_trap_i,
    input wire logic [15:0] ret_pc_i,
    input wire logic [7:0] regs_a_i,
    input wire logic [7:0] regs_x_i,
    input wire logic [7:0] ccr_i,
    input wire logic [7:0] bus_rdata_i,
    output logic [NUM_SRC-1:0] status_o,
    output logic ibit_o,
    output logic busy_o,
    output logic [15:0] bus_addr_o,
    output logic bus_rd_o,
    output logic [15:0] new_pc_o,
    output logic [7:0] queue_byte_o,
    output logic queue_vld_o,
    output logic [7:0] ccr_restored_o,
    output logic entry_done_o,
    output logic rti_done_o
);
    import cie_pkg::*;

    initial begin
        if (NUM_SRC < 1 || NUM_SRC > 64) begin
            $error("NUM_SRC out of range");
        end
    end

    typedef enum logic [3:0] {
        CIE_IDLE, CIE_PUSH, CIE_VEC_HI, CIE_VEC_LO, CIE_VEC_WAIT,
        CIE_FILL, CIE_FILL_WAIT, CIE_POP, CIE_POP_WAIT, CIE_END
    } cie_state_e;

    // fixed priority, lowest index wins
    function automatic logic [5:0] cie_pick(input logic [NUM_SRC-1:0] req);
        logic [5:0] idx;
        idx = 6'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    logic [NUM_SRC-1:0] ev_s1, ev_s2, ev_s3;
    logic [NUM_SRC-1:0] next_status;
    logic [NUM_SRC-1:0] qual;
    logic pend_irq;
    logic dbg_pend, next_dbg_pend;
    cie_state_e state, next_state;
    logic ibit, next_ibit;
    logic [7:0] sp, next_sp;
    logic [2:0] cnt, next_cnt;
    logic [15:0] vec_addr, next_vec_addr;
    logic [15:0] pc, next_pc;
    logic [15:0] addr, next_addr;
    logic rd, next_rd;
    logic [7:0] qbyte, next_qbyte;
    logic qvld, next_qvld;
    logic [7:0] ccr_rest, next_ccr_rest;
    logic edone, next_edone;
    logic rdone, next_rdone;
    logic is_rti, next_is_rti;
    logic mem_we;
    logic [7:0] mem_addr, mem_wdata, mem_rdata;

    // two flip-flop synchroniser plus edge history
    always_ff @(posedge mclk_i) begin
        ev_s1 <= event_i;
        ev_s2 <= ev_s1;
        ev_s3 <= ev_s2;
    end

    always_comb begin
        // set wins over clear
        next_status = (status_o & ~flag_clr_i)
            | (ev_s2 & ~ev_s3 & local_en_i);
        qual = status_o & local_en_i;
        pend_irq = (|qual) && !ibit;
    end

    always_comb begin
        next_state = state;
        next_ibit = ibit;
        next_sp = sp;
        next_cnt = cnt;
        next_vec_addr = vec_addr;
        next_pc = pc;
        next_addr = addr;
        next_rd = 1'b0;
        next_qbyte = qbyte;
        next_qvld = 1'b0;
        next_ccr_rest = ccr_rest;
        next_edone = 1'b0;
        next_rdone = 1'b0;
        next_is_rti = is_rti;
        next_dbg_pend = dbg_pend | dbg_trap_i;
        mem_we = 1'b0;
        mem_addr = sp;
        mem_wdata = 8'h00;
        case (state)
            CIE_IDLE: begin
                if (op_i == CIE_OP_CLI) begin
                    next_ibit = 1'b0;
                end
                if (insn_done_i) begin
                    if (op_i == CIE_OP_RTI) begin
                        next_is_rti = 1'b1;
                        next_cnt = 3'd0;
                        next_state = CIE_POP;
                    end else if (op_i == CIE_OP_SWI || dbg_pend || pend_irq) begin
                        next_is_rti = 1'b0;
                        next_cnt = 3'd0;
                        next_pc = ret_pc_i;
                        next_dbg_pend = 1'b0;
                        // trap uses top vector, sources below it
                        if (op_i == CIE_OP_SWI || dbg_pend) begin
                            next_vec_addr = CIE_VEC_TOP;
                        end else begin
                            next_vec_addr = CIE_VEC_TOP
                                - 16'({cie_pick(qual), 1'b0}) - 16'h0002;
                        end
                        next_state = CIE_PUSH;
                    end
                end
            end
            CIE_PUSH: begin
                mem_we = 1'b1;
                case (cnt)
                    3'd0: mem_wdata = ret_pc_i[7:0];
                    3'd1: mem_wdata = ret_pc_i[15:8];
                    3'd2: mem_wdata = regs_x_i;
                    3'd3: mem_wdata = regs_a_i;
                    default: mem_wdata = ccr_i;
                endcase
                next_sp = sp - 8'h01;
                next_cnt = cnt + 3'd1;
                if (cnt == 3'(CIE_STACK_BYTES - 1)) begin
                    next_ibit = 1'b1;
                    next_state = CIE_VEC_HI;
                end
            end
            CIE_VEC_HI: begin
                next_addr = vec_addr;
                next_rd = 1'b1;
                next_state = CIE_VEC_LO;
            end
            CIE_VEC_LO: begin
                next_pc[15:8] = bus_rdata_i;
                next_addr = vec_addr + 16'h0001;
                next_rd = 1'b1;
                next_state = CIE_VEC_WAIT;
            end
            CIE_VEC_WAIT: begin
                next_pc[7:0] = bus_rdata_i;
                next_cnt = 3'd0;
                next_state = CIE_FILL;
            end
            CIE_FILL: begin
                next_addr = pc + 16'(cnt);
                next_rd = 1'b1;
                next_state = CIE_FILL_WAIT;
            end
            CIE_FILL_WAIT: begin
                next_qbyte = bus_rdata_i;
                next_qvld = 1'b1;
                next_cnt = cnt + 3'd1;
                next_state = (cnt == 3'(CIE_QUEUE_BYTES - 1)) ? CIE_END : CIE_FILL;
            end
            CIE_POP: begin
                mem_addr = sp + 8'h01;
                next_sp = sp + 8'h01;
                next_state = CIE_POP_WAIT;
            end
            CIE_POP_WAIT: begin
                case (cnt)
                    3'd0: next_ccr_rest = mem_rdata;
                    3'd3: next_pc[15:8] = mem_rdata;
                    3'd4: next_pc[7:0] = mem_rdata;
                    default: ;
                endcase
                if (cnt == 3'd0) begin
                    next_ibit = mem_rdata[CIE_CCR_IBIT];
                end
                next_cnt = cnt + 3'd1;
                next_state = (cnt == 3'(CIE_STACK_BYTES - 1)) ? CIE_END : CIE_POP;
            end
            CIE_END: begin
                next_edone = !is_rti;
                next_rdone = is_rti;
                next_state = CIE_IDLE;
            end
            default: next_state = CIE_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_o <= '0;
            dbg_pend <= 1'b0;
            state <= CIE_IDLE;
            ibit <= 1'b1;
            sp <= CIE_SP_RESET[7:0];
            cnt <= 3'd0;
            vec_addr <= CIE_VEC_TOP;
            pc <= 16'h0000;
            addr <= 16'h0000;
            rd <= 1'b0;
            qbyte <= 8'h00;
            qvld <= 1'b0;
            ccr_rest <= CIE_CCR_RESET;
            edone <= 1'b0;
            rdone <= 1'b0;
            is_rti <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            status_o <= next_status;
            dbg_pend <= next_dbg_pend;
            state <= next_state;
            ibit <= next_ibit;
            sp <= next_sp;
            cnt <= next_cnt;
            vec_addr <= next_vec_addr;
            pc <= next_pc;
            addr <= next_addr;
            rd <= next_rd;
            qbyte <= next_qbyte;
            qvld <= next_qvld;
            ccr_rest <= next_ccr_rest;
            edone <= next_edone;
            rdone <= next_rdone;
            is_rti <= next_is_rti;
            busy_o <= (next_state != CIE_IDLE);
        end
    end

    assign ibit_o = ibit;
    assign bus_addr_o = addr;
    assign bus_rd_o = rd;
    assign new_pc_o = pc;
    assign queue_byte_o = qbyte;
    assign queue_vld_o = qvld;
    assign ccr_restored_o = ccr_rest;
    assign entry_done_o = edone;
    assign rti_done_o = rdone;

    cie_stack_mem #(
        .DEPTH(256),
        .AW(8)
    ) u_stack (
        .mclk_i(mclk_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );
endmodule

/* File: bench/cie_entry_assertions.sv */
// Purpose: port checks for entry logic
// Assumes: bound to cie_entry
// Notes: source 1 is the watched flag
`timescale 1ns/1ps
module cie_entry_assertions
    import cie_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [NUM_SRC-1:0] event_i,
    input wire logic [NUM_SRC-1:0] local_en_i,
    input wire logic insn_done_i,
    input wire cie_pkg::cie_op_e op_i,
    input wire logic dbg_trap_i,
    input wire logic [NUM_SRC-1:0] status_o,
    input wire logic ibit_o,
    input wire logic busy_o,
    input wire logic [15:0] bus_addr_o,
    input wire logic bus_rd_o,
    input wire logic queue_vld_o,
    input wire logic [7:0] ccr_restored_o,
    input wire logic entry_done_o,
    input wire logic rti_done_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] qcnt;
    logic [1:0] next_qcnt;
    logic dbg_wait;
    logic next_dbg_wait;
    logic take_any;
    // queue bytes seen in this sequence, debug trap still waiting
    always_comb begin
        next_qcnt = qcnt + 2'(queue_vld_o);
        take_any = !busy_o && insn_done_i && op_i != CIE_OP_RTI
            && (op_i == CIE_OP_SWI || dbg_wait
            || (!ibit_o && (status_o & local_en_i) != '0));
        next_dbg_wait = (dbg_wait || dbg_trap_i) && !take_any;
        if (rst_i || entry_done_o || rti_done_o) begin
            next_qcnt = 2'h0;
        end
        if (rst_i) begin
            next_dbg_wait = 1'b0;
        end
    end
    always_ff @(posedge mclk_i) begin
        qcnt <= next_qcnt;
        dbg_wait <= next_dbg_wait;
    end
    property p_rst; disable iff (1'b0) rst_i |=> ibit_o && !busy_o; endproperty
    a_rst: assert property (p_rst) else $error("mask after reset");
    property p_flag; $rose(event_i[1]) && local_en_i[1] |-> ##[1:4] status_o[1]; endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_take; $rose(busy_o) |-> $past(insn_done_i); endproperty
    a_take: assert property (p_take) else $error("entry mid insn");
    property p_hold;
        !busy_o && insn_done_i && op_i == CIE_OP_NONE && !dbg_trap_i && !dbg_wait
            && (ibit_o || (status_o & local_en_i) == '0) |=> !busy_o;
    endproperty
    a_hold: assert property (p_hold) else $error("masked taken");
    property p_vec; bus_rd_o && bus_addr_o >= 16'hFFEE |-> ibit_o; endproperty
    a_vec: assert property (p_vec) else $error("vector before mask");
    property p_len; $rose(busy_o) |-> ##[8:24] (entry_done_o || rti_done_o); endproperty
    a_len: assert property (p_len) else $error("sequence length");
    property p_q3; entry_done_o |-> qcnt + 2'(queue_vld_o) == 2'h3; endproperty
    a_q3: assert property (p_q3) else $error("queue count");
    property p_rti; rti_done_o |-> ##[0:1] ibit_o == ccr_restored_o[CIE_CCR_IBIT]; endproperty
    a_rti: assert property (p_rti) else $error("mask on return");
    property p_fall; $fell(ibit_o) |-> $past(op_i == CIE_OP_CLI || busy_o || rti_done_o);
    endproperty
    a_fall: assert property (p_fall) else $error("mask dropped");
endmodule
bind cie_entry cie_entry_assertions #(.NUM_SRC(NUM_SRC)) chk_u (.*);

/* File: bench/cie_bus_model.sv */
// Purpose: program memory seen by the sequencer
// Assumes: byte is low address xor 5A
// Notes: answers in the read cycle; idle bus shows inverted last byte
`timescale 1ns/1ps
module cie_bus_model (
    input wire logic mclk_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] last = 8'h00;
    // read data stands while the read strobe stands
    always_comb begin
        rdata_o = rd_i ? (addr_i[7:0] ^ 8'h5A) : ~last;
    end
    always @(posedge mclk_i) begin
        if (rd_i) begin
            last <= addr_i[7:0] ^ 8'h5A;
        end
    end
endmodule

/* File: bench/cie_entry_tb_top.sv */
// Purpose: scenario bench for entry logic
// Assumes: inputs change 1 ns after edge
// Notes: expected bytes from address xor 5A
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module cie_entry_tb_top;
    import cie_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] event_i = 8'h00, local_en_i = 8'h00, flag_clr_i = 8'h00;
    logic insn_done_i = 1'b0, dbg_trap_i = 1'b0;
    cie_op_e op_i = CIE_OP_NONE;
    logic [15:0] ret_pc_i = 16'h1234;
    logic [7:0] regs_a_i = 8'h11, regs_x_i = 8'h22, ccr_i = 8'h60, bus_rdata_i;
    logic [7:0] status_o, queue_byte_o, ccr_restored_o;
    logic ibit_o, busy_o, bus_rd_o, queue_vld_o, entry_done_o, rti_done_o;
    logic [15:0] bus_addr_o, new_pc_o;
    int err_total = 0, n_checks = 0, cyc_hw, cyc_sw;
    always #10 mclk_i = ~mclk_i;
    cie_entry dut_u (.*);
    cie_bus_model mem_u (.mclk_i(mclk_i), .rd_i(bus_rd_o), .addr_i(bus_addr_o),
        .rdata_o(bus_rdata_i));
    function automatic logic [15:0] vp(logic [15:0] v);
        return {v[7:0] ^ 8'h5A, (v[7:0] + 8'h01) ^ 8'h5A};
    endfunction
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic seq(cie_op_e op, logic dbg, logic [15:0] epc, output int cyc);
        int q;
        q = 0;
        cyc = 0;
        if (dbg) begin
            dbg_trap_i = 1'b1;
            tick();
            dbg_trap_i = 1'b0;
        end
        insn_done_i = 1'b1;
        op_i = op;
        tick();
        insn_done_i = 1'b0;
        op_i = CIE_OP_NONE;
        repeat (40) begin
            if (queue_vld_o === 1'b1) begin
                `CHK(queue_byte_o, 8'((epc[7:0] + 8'(q)) ^ 8'h5A))
                q++;
            end
            if (entry_done_o === 1'b1 || rti_done_o === 1'b1) break;
            tick();
            cyc++;
        end
        `CHK(new_pc_o, epc)
        if (op != CIE_OP_RTI) begin
            `CHK(q, 3)
            `CHK(ibit_o, 1'b1)
        end
        tick();
    endtask
    task automatic t_mask();
        local_en_i = 8'h06;
        event_i = 8'h0E;
        tick(4);
        `CHK(status_o, 8'h06)
        insn_done_i = 1'b1;
        tick();
        insn_done_i = 1'b0;
        tick();
        `CHK(busy_o, 1'b0)
        `CHK(ibit_o, 1'b1)
        `CHK(new_pc_o, 16'h0000)
        $display("test mask done");
    endtask
    task automatic t_irq();
        op_i = CIE_OP_CLI;
        tick();
        op_i = CIE_OP_NONE;
        tick(3);
        `CHK(busy_o, 1'b0)
        seq(CIE_OP_NONE, 1'b0, vp(16'hFFFA), cyc_hw);
        flag_clr_i = 8'h02;
        tick();
        flag_clr_i = 8'h00;
        `CHK(status_o, 8'h04)
        op_i = CIE_OP_CLI;
        tick();
        seq(CIE_OP_NONE, 1'b0, vp(16'hFFF8), cyc_hw);
        $display("test irq done");
    endtask
    task automatic t_trap();
        seq(CIE_OP_SWI, 1'b0, vp(16'hFFFE), cyc_sw);
        `CHK(cyc_sw, cyc_hw)
        flag_clr_i = 8'h04;
        tick();
        flag_clr_i = 8'h00;
        seq(CIE_OP_RTI, 1'b0, 16'h1234, cyc_sw);
        `CHK(ccr_restored_o, 8'h60)
        `CHK(ibit_o, 1'b0)
        seq(CIE_OP_NONE, 1'b1, vp(16'hFFFE), cyc_sw);
        $display("test trap done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk_i);
        err_total++;
        complete_run();
    end
    initial begin
        tick(20);
        rst_i = 1'b0;
        tick();
        `CHK(ibit_o, 1'b1)
        `CHK(status_o, 8'h00)
        t_mask();
        t_irq();
        t_trap();
        complete_run();
    end
endmodule
